// File: design/rail_seq_pkg.sv
// Constants, types and slot decoding shared by the rail strobe slot logic
package rail_seq_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] BACKUP_SLOT_ADDR  = 8'h24;
    localparam logic [7:0] SWREG_SLOT_ADDR   = 8'h25;
    localparam logic [7:0] BACKUP_SLOT_RESET = 8'h12;
    localparam logic [7:0] SWREG_SLOT_RESET  = 8'h63;
    // Reserved bits 7-6 and 3-2 of the backup register read as zero
    localparam logic [7:0] BACKUP_SLOT_MASK  = 8'h33;

    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int RAIL_A_LSB   = 0;
    localparam int RAIL_B_LSB   = 4;
    localparam int REG_LSB      = 0;
    localparam int SWITCH_LSB   = 4;
    localparam int NARROW_WIDTH = 2;
    localparam int WIDE_WIDTH   = 4;

    // ------------------------------------------------------------
    // Rails and strobes
    // ------------------------------------------------------------
    localparam int         NUM_RAILS        = 4;
    localparam int         RAIL_BUCK_A      = 0;
    localparam int         RAIL_BUCK_B      = 1;
    localparam int         RAIL_SWITCH      = 2;
    localparam int         RAIL_REG         = 3;
    localparam logic [3:0] BACKUP_RAIL_MASK = 4'h3;
    localparam logic [3:0] WIDE_RAIL_MASK   = 4'hc;
    localparam logic [3:0] RAIL_EN_RESET    = 4'h0;
    localparam logic [3:0] STROBE_NONE      = 4'h0;
    localparam logic [3:0] STROBE_FIRST     = 4'h1;
    localparam logic [3:0] STROBE_SECOND    = 4'h2;
    localparam logic [3:0] STROBE_WIDE_MIN  = 4'h3;
    localparam logic [3:0] STROBE_WIDE_MAX  = 4'ha;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b01,
        ST_APPLY = 2'b10
    } seq_state_e;

    // Strobe at which a slot code enables its rail, STROBE_NONE when unsequenced
    function automatic logic [3:0] slot_strobe(input logic [3:0] code, input logic wide);
        logic [3:0] s;
        s = STROBE_NONE;
        if (wide) begin
            if (code >= STROBE_WIDE_MIN && code <= STROBE_WIDE_MAX) begin
                s = code;
            end
        end else if (code == STROBE_FIRST || code == STROBE_SECOND) begin
            s = code;
        end
        return s;
    endfunction

endpackage

// File: design/slot_match_if.sv
// Carrier between the sequencer and its slot decoder
`timescale 1ns/100ps
interface slot_match_if #(
    parameter int N = 4
);
    logic [3:0]   code [N];
    logic [3:0]   strobe;
    logic [N-1:0] match;

    modport seq (output code, output strobe, input match);
    modport dec (input code, input strobe, output match);
endinterface

// File: design/slot_match.sv
// Per-rail comparison of slot codes against the strobe being executed
`timescale 1ns/100ps
module slot_match #(
    parameter int         N         = 4,
    parameter logic [3:0] WIDE_MASK = rail_seq_pkg::WIDE_RAIL_MASK
) (
    slot_match_if.dec mi
);

    // ------------------------------------------------------------
    // Decoders
    // ------------------------------------------------------------
    for (genvar i = 0; i < N; i++) begin : g_rail
        assign mi.match[i] = (mi.strobe != rail_seq_pkg::STROBE_NONE) &&
                             (rail_seq_pkg::slot_strobe(mi.code[i], WIDE_MASK[i]) == mi.strobe);
    end

endmodule

// File: design/rail_strobe_sequence_slots.sv
// Strobe slot registers and rail enable sequencing for backup bucks, switch and regulator
//
// Functional notes
// - Backup rail B slot bits 5-4: 1h strobe 1, 2h strobe 2, else unsequenced.
// - Backup rail A slot bits 1-0 decoded identically; 0h and 3h unsequenced.
// - Strobes 1 and 2 run only while freshness seal flag is 0.
// - With seal broken, sequencer never disables either backup buck rail.
// - Switch slot bits 7-4: codes 3h-Ah mean strobes 3-10, others unsequenced.
// - Backup slot register at 0x24, reset 0x12.
// - Switch and regulator slot register at 0x25, reset 0x63.
// - Unsequenced rails are neither enabled nor disabled by any strobe.
`timescale 1ns/100ps
module rail_strobe_sequence_slots (
    input  wire logic       sys_clk,
    input  wire logic       rst_b,
    input  wire logic       reg_wr_en,
    input  wire logic       reg_rd_en,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic      [7:0] reg_rdata,
    output logic            reg_rd_valid,
    output logic            reg_addr_err,
    input  wire logic       strobe_valid,
    input  wire logic [3:0] strobe_num,
    input  wire logic       strobe_up,
    input  wire logic       freshness_seal_flag,
    output logic            backup_buck_a_en,
    output logic            backup_buck_b_en,
    output logic            low_voltage_switch_en,
    output logic            linear_regulator_en
);

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    logic [7:0]               backup_slot_r;
    logic [7:0]               backup_slot_nxt;
    logic [7:0]               swreg_slot_r;
    logic [7:0]               swreg_slot_nxt;
    logic [7:0]               rdata_r;
    logic [7:0]               rdata_nxt;
    logic                     rd_valid_r;
    logic                     rd_valid_nxt;
    logic                     addr_err_r;
    logic                     addr_err_nxt;
    rail_seq_pkg::seq_state_e state_r;
    rail_seq_pkg::seq_state_e state_nxt;
    logic [3:0]               strobe_num_r;
    logic [3:0]               strobe_num_nxt;
    logic                     strobe_up_r;
    logic                     strobe_up_nxt;
    logic [3:0]               rail_en_r;
    logic [3:0]               rail_en_nxt;
    logic                     backup_strobe;

    slot_match_if #(.N(rail_seq_pkg::NUM_RAILS)) mi ();

    // ------------------------------------------------------------
    // Slot decoding
    // ------------------------------------------------------------
    assign mi.code[rail_seq_pkg::RAIL_BUCK_A] = {2'h0, backup_slot_r[rail_seq_pkg::RAIL_A_LSB +: 2]};
    assign mi.code[rail_seq_pkg::RAIL_BUCK_B] = {2'h0, backup_slot_r[rail_seq_pkg::RAIL_B_LSB +: 2]};
    assign mi.code[rail_seq_pkg::RAIL_SWITCH] = swreg_slot_r[rail_seq_pkg::SWITCH_LSB +: 4];
    assign mi.code[rail_seq_pkg::RAIL_REG]    = swreg_slot_r[rail_seq_pkg::REG_LSB +: 4];
    assign mi.strobe                          = (state_r == rail_seq_pkg::ST_APPLY) ?
                                                strobe_num_r : rail_seq_pkg::STROBE_NONE;

    slot_match #(
        .N         (rail_seq_pkg::NUM_RAILS),
        .WIDE_MASK (rail_seq_pkg::WIDE_RAIL_MASK)
    ) u_match (
        .mi (mi.dec)
    );

    // ------------------------------------------------------------
    // Register port
    // ------------------------------------------------------------
    // Read data lands one cycle after the request; a write and read of the same
    // register in one cycle returns the old value.
    always_comb begin
        backup_slot_nxt = backup_slot_r;
        swreg_slot_nxt  = swreg_slot_r;
        rdata_nxt       = rdata_r;
        rd_valid_nxt    = reg_rd_en;
        addr_err_nxt    = 1'b0;
        if (reg_addr == rail_seq_pkg::BACKUP_SLOT_ADDR) begin
            if (reg_wr_en) begin
                backup_slot_nxt = reg_wdata & rail_seq_pkg::BACKUP_SLOT_MASK;
            end
            if (reg_rd_en) begin
                rdata_nxt = backup_slot_r;
            end
        end else if (reg_addr == rail_seq_pkg::SWREG_SLOT_ADDR) begin
            if (reg_wr_en) begin
                swreg_slot_nxt = reg_wdata;
            end
            if (reg_rd_en) begin
                rdata_nxt = swreg_slot_r;
            end
        end else begin
            addr_err_nxt = reg_wr_en | reg_rd_en;
            if (reg_rd_en) begin
                rdata_nxt = 8'h00;
            end
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            backup_slot_r <= rail_seq_pkg::BACKUP_SLOT_RESET;
            swreg_slot_r  <= rail_seq_pkg::SWREG_SLOT_RESET;
            rdata_r       <= 8'h00;
            rd_valid_r    <= 1'b0;
            addr_err_r    <= 1'b0;
        end else begin
            backup_slot_r <= backup_slot_nxt;
            swreg_slot_r  <= swreg_slot_nxt;
            rdata_r       <= rdata_nxt;
            rd_valid_r    <= rd_valid_nxt;
            addr_err_r    <= addr_err_nxt;
        end
    end

    // ------------------------------------------------------------
    // Strobe sequencer
    // ------------------------------------------------------------
    // A strobe is latched in IDLE and applied in the next cycle, so slot
    // writes landing with the strobe are already in effect. Strobes offered
    // during APPLY are dropped; the core spaces them by at least two cycles.
    assign backup_strobe = (strobe_num_r == rail_seq_pkg::STROBE_FIRST) ||
                           (strobe_num_r == rail_seq_pkg::STROBE_SECOND);

    always_comb begin
        state_nxt      = state_r;
        strobe_num_nxt = strobe_num_r;
        strobe_up_nxt  = strobe_up_r;
        rail_en_nxt    = rail_en_r;
        case (state_r)
            rail_seq_pkg::ST_IDLE: begin
                if (strobe_valid) begin
                    strobe_num_nxt = strobe_num;
                    strobe_up_nxt  = strobe_up;
                    state_nxt      = rail_seq_pkg::ST_APPLY;
                end
            end
            rail_seq_pkg::ST_APPLY: begin
                state_nxt = rail_seq_pkg::ST_IDLE;
                if (!(freshness_seal_flag && backup_strobe)) begin
                    for (int i = 0; i < rail_seq_pkg::NUM_RAILS; i++) begin
                        if (mi.match[i]) begin
                            if (strobe_up_r) begin
                                rail_en_nxt[i] = 1'b1;
                            end else if (!(freshness_seal_flag && rail_seq_pkg::BACKUP_RAIL_MASK[i])) begin
                                rail_en_nxt[i] = 1'b0;
                            end
                        end
                    end
                end
            end
            default: begin
                state_nxt = rail_seq_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_b) begin
            state_r      <= rail_seq_pkg::ST_IDLE;
            strobe_num_r <= rail_seq_pkg::STROBE_NONE;
            strobe_up_r  <= 1'b0;
            rail_en_r    <= rail_seq_pkg::RAIL_EN_RESET;
        end else begin
            state_r      <= state_nxt;
            strobe_num_r <= strobe_num_nxt;
            strobe_up_r  <= strobe_up_nxt;
            rail_en_r    <= rail_en_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign reg_rdata             = rdata_r;
    assign reg_rd_valid          = rd_valid_r;
    assign reg_addr_err          = addr_err_r;
    assign backup_buck_a_en      = rail_en_r[rail_seq_pkg::RAIL_BUCK_A];
    assign backup_buck_b_en      = rail_en_r[rail_seq_pkg::RAIL_BUCK_B];
    assign low_voltage_switch_en = rail_en_r[rail_seq_pkg::RAIL_SWITCH];
    assign linear_regulator_en   = rail_en_r[rail_seq_pkg::RAIL_REG];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    sequence s_take;
        strobe_valid && state_r == rail_seq_pkg::ST_IDLE;
    endsequence

    sequence s_apply_up;
        state_r == rail_seq_pkg::ST_APPLY && strobe_up_r && !freshness_seal_flag;
    endsequence

    sequence s_apply_down;
        state_r == rail_seq_pkg::ST_APPLY && !strobe_up_r;
    endsequence

    a_rail_b_strobe1: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_take ##1 (s_apply_up and (strobe_num_r == 4'h1 && backup_slot_r[5:4] == 2'h1)) |=> backup_buck_b_en)
        else $error("backup rail b not enabled at strobe 1");

    a_rail_a_strobe2: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_apply_up and (strobe_num_r == 4'h2 && backup_slot_r[1:0] == 2'h2) |=> backup_buck_a_en)
        else $error("backup rail a not enabled at strobe 2");

    a_seal_skips_early: assert property (@(posedge sys_clk) disable iff (!rst_b)
        state_r == rail_seq_pkg::ST_APPLY && freshness_seal_flag && strobe_num_r <= 4'h2
        |=> rail_en_r == $past(rail_en_r))
        else $error("strobe 1 or 2 executed with seal broken");

    a_seal_keeps_backup: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_apply_down and freshness_seal_flag |=> rail_en_r[1:0] == $past(rail_en_r[1:0]))
        else $error("backup rail changed by a down strobe with seal broken");

    a_switch_slot_up: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_apply_up and (swreg_slot_r[7:4] == strobe_num_r && strobe_num_r >= 4'h3 && strobe_num_r <= 4'ha)
        |=> low_voltage_switch_en)
        else $error("switch not enabled at its strobe");

    a_backup_readback: assert property (@(posedge sys_clk) disable iff (!rst_b)
        reg_rd_en && reg_addr == 8'h24 |=> reg_rd_valid && reg_rdata == $past(backup_slot_r) && reg_rdata[7:6] == 2'h0)
        else $error("backup slot register readback wrong");

    a_swreg_readback: assert property (@(posedge sys_clk) disable iff (!rst_b)
        reg_rd_en && reg_addr == 8'h25 |=> reg_rdata == $past(swreg_slot_r))
        else $error("switch regulator slot register readback wrong");

    a_unsequenced_hold: assert property (@(posedge sys_clk) disable iff (!rst_b)
        state_r == rail_seq_pkg::ST_APPLY && (swreg_slot_r[7:4] < 4'h3 || swreg_slot_r[7:4] > 4'ha)
        |=> $stable(low_voltage_switch_en))
        else $error("unsequenced switch changed by a strobe");

    a_regulator_down: assert property (@(posedge sys_clk) disable iff (!rst_b)
        s_apply_down and (swreg_slot_r[3:0] == strobe_num_r && strobe_num_r >= 4'h3 && strobe_num_r <= 4'ha)
        |=> !linear_regulator_en)
        else $error("regulator not disabled at its strobe");

endmodule

// File: verif/slot_host_model.sv
// Host-side model that programs the slot registers over the parallel register port
`timescale 1ns/100ps
module slot_host_model (
    input  wire logic       sys_clk,
    output logic            reg_wr_en,
    output logic            reg_rd_en,
    output logic      [7:0] reg_addr,
    output logic      [7:0] reg_wdata,
    input  wire logic [7:0] reg_rdata,
    input  wire logic       reg_rd_valid,
    input  wire logic       reg_addr_err
);
    // ------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------
    initial begin
        reg_wr_en = 1'b0;
        reg_rd_en = 1'b0;
        reg_addr  = 8'h00;
        reg_wdata = 8'h00;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr_en <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr_en <= 1'b0;
        // Released lines carry the inverse so a stale value cannot pass
        reg_addr  <= ~a;
        reg_wdata <= ~d;
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v, output logic e);
        @(posedge sys_clk);
        reg_rd_en <= 1'b1;
        reg_addr  <= a;
        @(posedge sys_clk);
        reg_rd_en <= 1'b0;
        reg_addr  <= ~a;
        #1;
        d = reg_rdata;
        v = reg_rd_valid;
        e = reg_addr_err;
    endtask
endmodule

// File: verif/tb_rail_strobe_sequence_slots.sv
// Self-checking bench for the rail strobe slot registers and sequencing
`timescale 1ns/100ps
`define CHK(name, exp, got) begin total_checks++; if ((got) !== (exp)) begin errors++; \
    $display("Error %s expected %h seen %h", name, exp, got); end end
module tb_rail_strobe_sequence_slots;
    logic       sys_clk;
    logic       rst_b;
    logic       reg_wr_en;
    logic       reg_rd_en;
    logic [7:0] reg_addr;
    logic [7:0] reg_wdata;
    logic [7:0] reg_rdata;
    logic       reg_rd_valid;
    logic       reg_addr_err;
    logic       strobe_valid;
    logic [3:0] strobe_num;
    logic       strobe_up;
    logic       seal;
    logic [3:0] rails;
    logic [7:0] d;
    logic       v;
    logic       e;
    int         errors;
    int         total_checks;
    int         cycles;

    // ------------------------------------------------------------
    // Instances and clock
    // ------------------------------------------------------------
    rail_strobe_sequence_slots uut (.sys_clk(sys_clk), .rst_b(rst_b), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rd_valid(reg_rd_valid), .reg_addr_err(reg_addr_err), .strobe_valid(strobe_valid),
        .strobe_num(strobe_num), .strobe_up(strobe_up), .freshness_seal_flag(seal),
        .backup_buck_a_en(rails[0]), .backup_buck_b_en(rails[1]),
        .low_voltage_switch_en(rails[2]), .linear_regulator_en(rails[3]));

    slot_host_model host (.sys_clk(sys_clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rd_valid(reg_rd_valid), .reg_addr_err(reg_addr_err));

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    // Ceiling well above the roughly 1800 cycles the sequence needs
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            print_verdict();
        end
    end

    // ------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------
    task automatic print_verdict();
        $display("Checks %0d mismatches %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Strobe taken at the next edge; rails settle one edge later
    task automatic fire(input logic [3:0] n, input logic up);
        @(posedge sys_clk);
        strobe_valid <= 1'b1;
        strobe_num   <= n;
        strobe_up    <= up;
        @(posedge sys_clk);
        strobe_valid <= 1'b0;
        strobe_num   <= ~n;
        @(posedge sys_clk);
        #1;
    endtask

    task automatic set_seal(input logic s);
        @(posedge sys_clk);
        seal <= s;
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        errors       = 0;
        total_checks = 0;
        cycles       = 0;
        rst_b        = 1'b0;
        strobe_valid = 1'b0;
        strobe_num   = 4'h0;
        strobe_up    = 1'b0;
        seal         = 1'b0;
        repeat (5) @(posedge sys_clk);
        rst_b <= 1'b1;
        host.rd(8'h24, d, v, e);
        `CHK("backup reset", 8'h12, d)
        `CHK("read valid", 1'b1, v)
        `CHK("mapped err", 1'b0, e)
        host.rd(8'h25, d, v, e);
        `CHK("swreg reset", 8'h63, d)
        host.rd(8'h26, d, v, e);
        `CHK("unmapped data", 8'h00, d)
        `CHK("unmapped err", 1'b1, e)
        `CHK("rails reset", 4'h0, rails)
        // A write to an unmapped address must not alias onto either slot register
        host.wr(8'h26, 8'h00);
        host.rd(8'h25, d, v, e);
        `CHK("unmapped write", 8'h63, d)
        `CHK("mapped err b", 1'b0, e)
        host.rd(8'h24, d, v, e);
        `CHK("unmapped write b", 8'h12, d)
        host.wr(8'h24, 8'hff);
        host.rd(8'h24, d, v, e);
        `CHK("backup reserved", 8'h33, d)
        host.wr(8'h24, 8'h12);
        fire(4'h1, 1'b1);
        `CHK("strobe 1", 4'h2, rails)
        fire(4'h2, 1'b1);
        `CHK("strobe 2", 4'h3, rails)
        fire(4'h3, 1'b1);
        `CHK("strobe 3", 4'hb, rails)
        fire(4'h6, 1'b1);
        `CHK("strobe 6", 4'hf, rails)
        set_seal(1'b1);
        fire(4'h1, 1'b0);
        fire(4'h2, 1'b0);
        `CHK("sealed down", 4'hf, rails)
        fire(4'h6, 1'b0);
        fire(4'h3, 1'b0);
        `CHK("wide down", 4'h3, rails)
        set_seal(1'b0);
        fire(4'h2, 1'b0);
        `CHK("open down", 4'h2, rails)
        set_seal(1'b1);
        fire(4'h2, 1'b1);
        `CHK("sealed up", 4'h2, rails)
        set_seal(1'b0);
        fire(4'h1, 1'b0);
        `CHK("open down b", 4'h0, rails)
        // Narrow codes: each field alone would hide a swapped pair, so both share one code
        for (int c = 0; c < 4; c++) begin
            host.wr(8'h24, {2'b00, c[1:0], 2'b00, c[1:0]});
            fire(4'h1, 1'b1);
            fire(4'h2, 1'b1);
            `CHK("narrow up", (c == 1 || c == 2) ? 4'h3 : 4'h0, rails)
            fire(4'h1, 1'b0);
            fire(4'h2, 1'b0);
            `CHK("narrow down", 4'h0, rails)
        end
        host.wr(8'h24, 8'h11);
        fire(4'h1, 1'b1);
        host.wr(8'h24, 8'h33);
        fire(4'h1, 1'b0);
        fire(4'h2, 1'b0);
        `CHK("unsequenced hold", 4'h3, rails)
        host.wr(8'h24, 8'h00);
        fire(4'h1, 1'b0);
        `CHK("code zero hold", 4'h3, rails)
        host.wr(8'h24, 8'h11);
        fire(4'h1, 1'b0);
        host.wr(8'h24, 8'h00);
        // Wide codes against every strobe number, including 0 and 11 to 15
        for (int c = 0; c < 16; c++) begin
            host.wr(8'h25, {c[3:0], c[3:0]});
            host.rd(8'h25, d, v, e);
            `CHK("swreg rw", {c[3:0], c[3:0]}, d)
            for (int k = 0; k < 16; k++) begin
                fire(k[3:0], 1'b1);
            end
            `CHK("wide up", (c >= 3 && c <= 10) ? 4'hc : 4'h0, rails)
            for (int k = 0; k < 16; k++) begin
                fire(k[3:0], 1'b0);
            end
            `CHK("wide down", 4'h0, rails)
        end
        // Second reset after the slots were rewritten: reset values must return
        host.wr(8'h25, 8'h66);
        fire(4'h6, 1'b1);
        `CHK("rewritten slots", 4'hc, rails)
        @(posedge sys_clk);
        rst_b <= 1'b0;
        repeat (2) @(posedge sys_clk);
        rst_b <= 1'b1;
        host.rd(8'h25, d, v, e);
        `CHK("swreg second reset", 8'h63, d)
        `CHK("rails second reset", 4'h0, rails)
        host.rd(8'h24, d, v, e);
        `CHK("backup second reset", 8'h12, d)
        fire(4'h6, 1'b1);
        `CHK("reset slot strobe 6", 4'h4, rails)
        print_verdict();
    end
endmodule
